// file: shared/gtc_pkg.sv
// Package: register map, field positions and reset values of the gated 16-bit timer/counter
package gtc_pkg;
  // ----------------------------------------------------------------
  // Register indices (printed offsets not all multiples of four)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_INTERRUPT_CONTROL = 8'h0B;
  localparam logic [7:0] IDX_PERIPHERAL_FLAGS = 8'h0C;
  localparam logic [7:0] IDX_COUNT_LOW_BYTE = 8'h0E;
  localparam logic [7:0] IDX_COUNT_HIGH_BYTE = 8'h0F;
  localparam logic [7:0] IDX_COUNTER_CONTROL = 8'h10;
  localparam logic [7:0] IDX_PERIPHERAL_ENABLES = 8'h8C;
  localparam logic [7:0] IDX_SYSTEM_CONFIG = 8'hF0;
  localparam int ADDR_W = 10;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CC_COUNTER_ON = 0;
  localparam int CC_CLOCK_SOURCE_SELECT = 1;
  localparam int CC_NO_SYNC_SELECT = 2;
  localparam int CC_CRYSTAL_OSC_ENABLE = 3;
  localparam int CC_PRESCALE_LO = 4;
  localparam int CC_GATE_ENABLE = 6;
  localparam int PF_OVERFLOW_FLAG = 0;
  localparam int PE_OVERFLOW_IRQ_ENABLE = 0;
  localparam int IC_PERIPHERAL_IRQ_ENABLE = 6;
  localparam int IC_GLOBAL_IRQ_ENABLE = 7;
  localparam int SC_INTERNAL_OSC = 0;
  localparam int SC_SLEEP = 1;
  localparam int SC_FULL_RESET = 2;
  // ----------------------------------------------------------------
  // Reset values and masks
  // ----------------------------------------------------------------
  localparam logic [7:0] CC_RESET = 8'h00;
  localparam logic [7:0] CC_MASK = 8'h7F;
  localparam logic [7:0] FLAG_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [1:0] QUARTER_LAST = 2'h3;
  // Prescale field codes
  localparam logic [1:0] PS_DIV1 = 2'h0;
  localparam logic [1:0] PS_DIV2 = 2'h1;
  localparam logic [1:0] PS_DIV4 = 2'h2;
  localparam logic [1:0] PS_DIV8 = 2'h3;
endpackage : gtc_pkg

// file: verilog/gtc_timer.sv
// Gated 16-bit timer/counter with APB register access
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
module gtc_timer
  import gtc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_clock_pin,
  input wire logic crystal_out_pin,
  input wire logic gate_pin_n,
  input wire logic port_dir_bit5,
  input wire logic port_dir_bit4,
  input wire logic port_pin5,
  input wire logic port_pin4,
  output logic port_dir_bit5_eff,
  output logic port_dir_bit4_eff,
  output logic port_pin5_eff,
  output logic port_pin4_eff,
  output logic crystal_osc_on,
  output logic irq,
  output logic wake
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] control;
    logic [7:0] intctl;
    logic overflow_flag;
    logic overflow_irq_enable;
    logic [7:0] sysconf;
    logic [15:0] count;
    logic [2:0] prescale;
    logic [1:0] quarter;
    logic src_sync1;
    logic src_sync2;
    logic src_prev;
    logic armed;
    logic [31:0] rdata;
    logic ready;
    logic slverr;
    logic dir5;
    logic dir4;
    logic pin5;
    logic pin4;
    logic osc_on;
    logic irq;
    logic wake;
  } gtc_state_t;

  gtc_state_t state_reg;
  gtc_state_t state_next;

  logic [7:0] idx;
  logic access_ok;
  logic wr;
  logic rd_phase;
  logic ext_src;
  logic gate_open;
  logic tick_in;
  logic tick_out;
  logic [2:0] ps_next;
  logic asleep;
  logic async_mode;
  logic ovf_set;

  // Decode word address; low two bits must be zero
  assign idx = paddr[9:2];
  assign access_ok = (paddr[1:0] == 2'h0) &&
    (idx == IDX_INTERRUPT_CONTROL || idx == IDX_PERIPHERAL_FLAGS ||
     idx == IDX_COUNT_LOW_BYTE || idx == IDX_COUNT_HIGH_BYTE ||
     idx == IDX_COUNTER_CONTROL || idx == IDX_PERIPHERAL_ENABLES ||
     idx == IDX_SYSTEM_CONFIG);
  assign wr = psel && penable && pwrite && !state_reg.ready && access_ok;
  assign rd_phase = psel && !penable;

  always_comb begin
    state_next = state_reg;
    asleep = state_reg.sysconf[SC_SLEEP];
    ovf_set = 1'b0;
    // ----------------------------------------------------------------
    // Count source selection
    // ----------------------------------------------------------------
    // crystal honoured only when internal oscillator runs
    state_next.osc_on = state_reg.control[CC_CRYSTAL_OSC_ENABLE] &&
      state_reg.sysconf[SC_INTERNAL_OSC];
    // crystal drives pin path when enabled
    ext_src = state_reg.osc_on ? crystal_out_pin : ext_clock_pin;
    // async mode only with external source
    async_mode = state_reg.control[CC_CLOCK_SOURCE_SELECT] &&
      state_reg.control[CC_NO_SYNC_SELECT];
    // two-stage synchroniser; async mode also passes through both stages
    state_next.src_sync1 = ext_src;
    state_next.src_sync2 = state_reg.src_sync1;
    state_next.src_prev = state_reg.src_sync2;
    // gate opens counting while pin low
    gate_open = state_reg.control[CC_COUNTER_ON] &&
      (!state_reg.control[CC_GATE_ENABLE] || !gate_pin_n);
    // sleep stops all but asynchronous counting
    if (asleep && !async_mode) begin
      gate_open = 1'b0;
    end
    // instruction clock is pclk divided by four
    state_next.quarter = state_reg.quarter + 2'h1;
    tick_in = 1'b0;
    if (state_reg.control[CC_CLOCK_SOURCE_SELECT]) begin
      // falling edge arms the rising-edge counter
      if (!state_reg.src_sync2 && state_reg.src_prev) begin
        state_next.armed = 1'b1;
      end
      tick_in = state_reg.armed && state_reg.src_sync2 && !state_reg.src_prev;
    end else begin
      tick_in = (state_reg.quarter == QUARTER_LAST);
    end
    if (!state_reg.control[CC_COUNTER_ON]) begin
      state_next.armed = 1'b0;
    end
    // ----------------------------------------------------------------
    // Prescaler and count
    // ----------------------------------------------------------------
    ps_next = state_reg.prescale + 3'h1;
    unique case (state_reg.control[CC_PRESCALE_LO +: 2])
      PS_DIV1: tick_out = 1'b1;
      PS_DIV2: tick_out = state_reg.prescale[0];
      PS_DIV4: tick_out = &state_reg.prescale[1:0];
      PS_DIV8: tick_out = &state_reg.prescale;
    endcase
    tick_out = tick_out && tick_in && gate_open;
    if (tick_in && gate_open) begin
      state_next.prescale = ps_next;
    end
    if (tick_out) begin
      // wrap to zero sets overflow flag
      state_next.count = state_reg.count + 16'h0001;
      ovf_set = (state_reg.count == 16'hFFFF);
      if (ovf_set) begin
        state_next.overflow_flag = 1'b1;
      end
    end
    // ----------------------------------------------------------------
    // APB access
    // ----------------------------------------------------------------
    state_next.ready = psel && penable && !state_reg.ready;
    state_next.slverr = psel && penable && !state_reg.ready && !access_ok;
    if (rd_phase) begin
      state_next.rdata = 32'h0000_0000;
      unique case (idx)
        IDX_INTERRUPT_CONTROL: state_next.rdata[7:0] = state_reg.intctl;
        IDX_PERIPHERAL_FLAGS: state_next.rdata[PF_OVERFLOW_FLAG] = state_reg.overflow_flag;
        // bytes read directly from the single count register
        IDX_COUNT_LOW_BYTE: state_next.rdata[7:0] = state_reg.count[7:0];
        IDX_COUNT_HIGH_BYTE: state_next.rdata[7:0] = state_reg.count[15:8];
        IDX_COUNTER_CONTROL: state_next.rdata[7:0] = state_reg.control & CC_MASK;
        IDX_PERIPHERAL_ENABLES: begin
          state_next.rdata[PE_OVERFLOW_IRQ_ENABLE] = state_reg.overflow_irq_enable;
        end
        IDX_SYSTEM_CONFIG: state_next.rdata[7:0] = state_reg.sysconf;
        default: state_next.rdata = 32'h0000_0000;
      endcase
    end
    if (wr) begin
      unique case (idx)
        IDX_INTERRUPT_CONTROL: state_next.intctl = pwdata[7:0];
        IDX_PERIPHERAL_FLAGS: begin
          // hardware set wins over software clear
          state_next.overflow_flag = (pwdata[PF_OVERFLOW_FLAG] && state_reg.overflow_flag) ||
            ovf_set;
        end
        IDX_COUNT_LOW_BYTE: begin
          state_next.count[7:0] = pwdata[7:0];
          state_next.prescale = 3'h0;
        end
        IDX_COUNT_HIGH_BYTE: begin
          state_next.count[15:8] = pwdata[7:0];
          state_next.prescale = 3'h0;
        end
        IDX_COUNTER_CONTROL: begin
          state_next.control = pwdata[7:0] & CC_MASK;
          state_next.armed = 1'b0;
        end
        IDX_PERIPHERAL_ENABLES: begin
          state_next.overflow_irq_enable = pwdata[PE_OVERFLOW_IRQ_ENABLE];
        end
        IDX_SYSTEM_CONFIG: state_next.sysconf = pwdata[7:0];
        default: state_next.sysconf = state_reg.sysconf;
      endcase
    end
    // ----------------------------------------------------------------
    // Interrupt, wake and port overrides
    // ----------------------------------------------------------------
    // all four conditions gate the interrupt
    state_next.irq = state_reg.overflow_flag && state_reg.overflow_irq_enable &&
      state_reg.intctl[IC_PERIPHERAL_IRQ_ENABLE] && state_reg.intctl[IC_GLOBAL_IRQ_ENABLE];
    // wake needs counter on and both enables
    state_next.wake = asleep && state_reg.overflow_flag &&
      state_reg.control[CC_COUNTER_ON] && state_reg.overflow_irq_enable &&
      state_reg.intctl[IC_PERIPHERAL_IRQ_ENABLE];
    // crystal forces direction one, pins zero
    state_next.dir5 = state_reg.osc_on | port_dir_bit5;
    state_next.dir4 = state_reg.osc_on | port_dir_bit4;
    state_next.pin5 = !state_reg.osc_on && port_pin5;
    state_next.pin4 = !state_reg.osc_on && port_pin4;
    // warm reset keeps count and control
    if (wr && idx == IDX_SYSTEM_CONFIG && pwdata[SC_FULL_RESET]) begin
      state_next.intctl[7:1] = FLAG_RESET[7:1];
      state_next.overflow_flag = 1'b0;
      state_next.overflow_irq_enable = 1'b0;
      state_next.sysconf[SC_FULL_RESET] = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // power-on clears control; count is defined as zero here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign prdata = state_reg.rdata;
  assign pready = state_reg.ready;
  assign pslverr = state_reg.slverr;
  assign port_dir_bit5_eff = state_reg.dir5;
  assign port_dir_bit4_eff = state_reg.dir4;
  assign port_pin5_eff = state_reg.pin5;
  assign port_pin4_eff = state_reg.pin4;
  assign crystal_osc_on = state_reg.osc_on;
  assign irq = state_reg.irq;
  assign wake = state_reg.wake;

endmodule : gtc_timer

// file: dv/gtc_timer_assertions.sv
// Checker: bus handshake and port forcing properties of the timer
`timescale 1ns/1ps
module gtc_timer_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic port_pin4,
  input wire logic port_dir_bit5_eff,
  input wire logic port_dir_bit4_eff,
  input wire logic port_pin5_eff,
  input wire logic port_pin4_eff,
  input wire logic crystal_osc_on
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_access;
    (psel && !penable) ##1 (psel && penable);
  endsequence
  sequence s_no_write;
    !(psel && penable && pwrite);
  endsequence
  a_ready_wait: assert property (s_access |=> pready) else $error("pready late");
  a_ready_single: assert property (pready |=> !pready) else $error("pready too long");
  a_ready_cause: assert property (pready |-> psel && penable && $past(penable))
    else $error("pready without access");
  a_err_pair: assert property (pslverr |-> pready) else $error("pslverr alone");
  a_rdata_hold: assert property (!$past(psel) |-> $stable(prdata))
    else $error("prdata moved while idle");
  a_xtal_force: assert property (crystal_osc_on ##1 crystal_osc_on |->
    port_dir_bit5_eff && port_dir_bit4_eff && !port_pin5_eff && !port_pin4_eff)
    else $error("port not forced");
  a_xtal_quiet: assert property (s_no_write [*3] |-> $stable(crystal_osc_on))
    else $error("crystal enable moved");
  a_pin_pass: assert property ((!crystal_osc_on && $stable(port_pin4)) [*3]
    |-> port_pin4_eff == port_pin4) else $error("pin not passed");
endmodule : gtc_timer_assertions
bind gtc_timer gtc_timer_assertions u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .port_pin4(port_pin4), .port_dir_bit5_eff(port_dir_bit5_eff),
  .port_dir_bit4_eff(port_dir_bit4_eff), .port_pin5_eff(port_pin5_eff),
  .port_pin4_eff(port_pin4_eff), .crystal_osc_on(crystal_osc_on));

// file: dv/gtc_ext_source.sv
// Partner model: external count clock, crystal line and gate level
`timescale 1ns/1ps
module gtc_ext_source #(
  parameter int HALF = 4
) (
  input wire logic pclk,
  input wire logic run,
  input wire logic gate_req,
  output logic ext_clock_pin,
  output logic crystal_out_pin,
  output logic gate_pin_n
);
  int cnt = 0;
  initial begin
    ext_clock_pin = 1'b0;
    crystal_out_pin = 1'b0;
  end
  // Clock stands low between bursts; each level lasts HALF cycles, three at least
  always @(posedge pclk) begin
    crystal_out_pin <= ~crystal_out_pin;
    if (run || ext_clock_pin) begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1) ext_clock_pin <= ~ext_clock_pin;
    end
  end
  assign gate_pin_n = gate_req;
endmodule : gtc_ext_source

// file: dv/gtc_timer_tb_top.sv
// Testbench: register access, counting, overflow and crystal scenarios
`timescale 1ns/1ps
module gtc_timer_tb_top;
  import gtc_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = 32'h0;
  logic run = 1'b0;
  logic gate_req = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, ext_clk, xtal, gate_n, dir5, dir4, pin5, pin4, xon, irq, wake;
  logic last_err;
  logic [7:0] last_rd;
  int fail_count = 0;
  int checked = 0;
  int cycles = 0;
  always #2 pclk = ~pclk;
  gtc_timer u_gtc_timer (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_clock_pin(ext_clk), .crystal_out_pin(xtal),
    .gate_pin_n(gate_n), .port_dir_bit5(1'b0), .port_dir_bit4(1'b0), .port_pin5(1'b1),
    .port_pin4(1'b1), .port_dir_bit5_eff(dir5), .port_dir_bit4_eff(dir4),
    .port_pin5_eff(pin5), .port_pin4_eff(pin4), .crystal_osc_on(xon), .irq(irq),
    .wake(wake));
  gtc_ext_source #(.HALF(4)) u_src (.pclk(pclk), .run(run), .gate_req(gate_req),
    .ext_clock_pin(ext_clk), .crystal_out_pin(xtal), .gate_pin_n(gate_n));
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    last_rd = prdata[7:0];
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask : apb
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask : wr
  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    apb(1'b0, idx, 8'h00);
    chk($sformatf("index %h", idx), e, last_rd);
  endtask : rd
  task automatic burst(input int n);
    run <= 1'b1;
    repeat (n * 8) @(posedge pclk);
    run <= 1'b0;
    repeat (24) @(posedge pclk);
  endtask : burst
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test
  // Ceiling well above the roughly one thousand cycles the tests need
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      end_of_test();
    end
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd(IDX_COUNTER_CONTROL, 8'h00);
    rd(IDX_PERIPHERAL_FLAGS, 8'h00);
    rd(IDX_PERIPHERAL_ENABLES, 8'h00);
    rd(8'h20, 8'h00);
    chk("pslverr", 8'h01, {7'h0, last_err});
    wr(IDX_COUNTER_CONTROL, 8'hFF);
    rd(IDX_COUNTER_CONTROL, 8'h7F);
    $display("access test done");
    for (int ps = 0; ps < 4; ps++) begin
      wr(IDX_COUNTER_CONTROL, 8'h00);
      wr(IDX_COUNT_LOW_BYTE, 8'h00);
      wr(IDX_COUNT_HIGH_BYTE, 8'h00);
      wr(IDX_COUNTER_CONTROL, 8'h03 | 8'(ps << 4));
      burst(9);
      wr(IDX_COUNTER_CONTROL, 8'h00);
      rd(IDX_COUNT_LOW_BYTE, 8'h08 >> ps);
    end
    wr(IDX_COUNT_LOW_BYTE, 8'h00);
    wr(IDX_COUNTER_CONTROL, 8'h43);
    burst(5);
    gate_req <= 1'b1;
    burst(5);
    wr(IDX_COUNTER_CONTROL, 8'h00);
    rd(IDX_COUNT_LOW_BYTE, 8'h04);
    $display("counting test done");
    wr(IDX_COUNT_LOW_BYTE, 8'hFF);
    wr(IDX_COUNT_HIGH_BYTE, 8'hFF);
    wr(IDX_COUNTER_CONTROL, 8'h03);
    gate_req <= 1'b0;
    burst(2);
    rd(IDX_COUNT_HIGH_BYTE, 8'h00);
    rd(IDX_PERIPHERAL_FLAGS, 8'h01);
    wr(IDX_PERIPHERAL_ENABLES, 8'h01);
    wr(IDX_INTERRUPT_CONTROL, 8'h40);
    chk("irq", 8'h00, {7'h0, irq});
    wr(IDX_SYSTEM_CONFIG, 8'h02);
    chk("wake", 8'h01, {7'h0, wake});
    wr(IDX_INTERRUPT_CONTROL, 8'hC0);
    chk("irq", 8'h01, {7'h0, irq});
    wr(IDX_PERIPHERAL_FLAGS, 8'h01);
    chk("irq", 8'h01, {7'h0, irq});
    wr(IDX_PERIPHERAL_FLAGS, 8'h00);
    chk("wake", 8'h00, {7'h0, wake});
    chk("irq", 8'h00, {7'h0, irq});
    $display("overflow test done");
    wr(IDX_COUNTER_CONTROL, 8'h08);
    chk("xtal", 8'h00, {7'h0, xon});
    wr(IDX_SYSTEM_CONFIG, 8'h01);
    chk("xtal", 8'h01, {7'h0, xon});
    chk("ports", 8'h0C, {4'h0, dir5, dir4, pin5, pin4});
    wr(IDX_COUNT_LOW_BYTE, 8'h5A);
    wr(IDX_SYSTEM_CONFIG, 8'h05);
    rd(IDX_COUNTER_CONTROL, 8'h08);
    rd(IDX_COUNT_LOW_BYTE, 8'h5A);
    chk("ports", 8'h0C, {4'h0, dir5, dir4, pin5, pin4});
    wr(IDX_COUNTER_CONTROL, 8'h00);
    chk("ports", 8'h03, {4'h0, dir5, dir4, pin5, pin4});
    $display("crystal test done");
    // Control is on for 44 edges, a whole number of instruction cycles
    wr(IDX_COUNT_LOW_BYTE, 8'h00);
    wr(IDX_COUNTER_CONTROL, 8'h01);
    repeat (38) @(posedge pclk);
    wr(IDX_COUNTER_CONTROL, 8'h00);
    rd(IDX_COUNT_LOW_BYTE, 8'h0B);
    wr(IDX_COUNT_LOW_BYTE, 8'h00);
    wr(IDX_SYSTEM_CONFIG, 8'h03);
    wr(IDX_COUNTER_CONTROL, 8'h07);
    burst(3);
    wr(IDX_COUNTER_CONTROL, 8'h00);
    rd(IDX_COUNT_LOW_BYTE, 8'h02);
    wr(IDX_COUNT_LOW_BYTE, 8'h00);
    wr(IDX_COUNTER_CONTROL, 8'h03);
    burst(3);
    wr(IDX_COUNTER_CONTROL, 8'h00);
    rd(IDX_COUNT_LOW_BYTE, 8'h00);
    $display("sleep test done");
    end_of_test();
  end
endmodule : gtc_timer_tb_top
